// ---- core/fbr_pkg.sv ----
// Package of constants and types for the flash busy and reset host controller
package fbr_pkg;
    localparam int unsigned CLK_HZ         = 40000000;
    localparam int unsigned RST_LOW_NS     = 25000;
    localparam int unsigned RST_LOW_CYC    = (RST_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned RST_REC_NS     = 1000;
    localparam int unsigned RST_REC_CYC    = (RST_REC_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned WR_LOW_NS      = 100;
    localparam int unsigned WR_LOW_CYC     = (WR_LOW_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned CNT_W          = 16;
    localparam int unsigned DATA_W         = 16;
    localparam int unsigned ADDR_W         = 24;
    localparam logic [7:0]  CMD_READ_ARRAY = 8'hff;
    localparam logic [7:0]  CMD_CLR_STATUS = 8'h50;
    localparam logic [7:0]  CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0]  CMD_CLR_LOCKS  = 8'hd0;
    localparam logic [7:0]  CMD_ERASE_SET  = 8'h20;
    localparam logic [7:0]  CMD_PROG_SET   = 8'h40;
    localparam int unsigned SUPPLY_ERR_POS = 3;
    localparam int unsigned ERASE_ERR_POS  = 5;
    localparam logic        SEL_ON         = 1'b1;
    localparam logic        DESEL          = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_WR    = 3'h1,
        ST_BUSY  = 3'h3,
        ST_RDARR = 3'h2,
        ST_RST   = 3'h6,
        ST_REC   = 3'h7
    } fbr_state_e;

    typedef enum logic [1:0] {
        OP_NONE  = 2'h0,
        OP_ERASE = 2'h1,
        OP_LOCK  = 2'h2,
        OP_PROG  = 2'h3
    } fbr_op_e;
endpackage : fbr_pkg

// ---- core/fbr_sync.sv ----
// Two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module fbr_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta_q <= '0;
            sync_o <= '0;
        end
        else
        begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : fbr_sync

// ---- core/fbr_host.sv ----
// Host controller driving a parallel flash: command writes, busy wait, reset
`timescale 1ns/1ps
module fbr_host (
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      req_valid_i,
    output logic                           req_ready_o,
    input  wire fbr_pkg::fbr_op_e          req_op_i,
    input  wire logic [fbr_pkg::ADDR_W-1:0] req_addr_i,
    input  wire logic [fbr_pkg::DATA_W-1:0] req_data_i,
    input  wire logic                      reset_req_i,
    output logic                           done_o,
    output logic                           aborted_o,
    output logic                           retry_needed_o,
    output logic [1:0]                     retry_op_o,
    output logic [fbr_pkg::ADDR_W-1:0]     flash_addr_o,
    output logic [fbr_pkg::DATA_W-1:0]     flash_dq_o,
    output logic                           flash_dq_oe_o,
    output logic                           write_strobe_n_o,
    output logic                           chip_select_0_o,
    output logic                           reset_powerdown_n_o,
    input  wire logic                      busy_status_pin_i
);
    typedef struct packed {
        fbr_pkg::fbr_state_e        st;
        logic [fbr_pkg::CNT_W-1:0]  cnt;
        logic                       second;
        logic [1:0]                 op;
        logic [1:0]                 retry_op;
        logic                       retry;
        logic                       done;
        logic                       aborted;
        logic                       was_busy;
        logic [fbr_pkg::ADDR_W-1:0] addr;
        logic [fbr_pkg::DATA_W-1:0] dq;
        logic                       dq_oe;
        logic                       we_n;
        logic                       cs;
        logic                       rp_n;
    } fbr_state_s;

    fbr_state_s s_q;
    fbr_state_s s_d;
    logic       busy_sync;

    // Busy pin is pulled low while busy; inverted so the reset value means idle
    fbr_sync #(
        .W (1)
    ) u_busy_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (~busy_status_pin_i),
        .sync_o  (busy_sync)
    );

    function automatic logic [7:0] first_cmd(input logic [1:0] op);
        case (op)
            fbr_pkg::OP_ERASE: first_cmd = fbr_pkg::CMD_ERASE_SET;
            fbr_pkg::OP_LOCK:  first_cmd = fbr_pkg::CMD_LOCK_SETUP;
            fbr_pkg::OP_PROG:  first_cmd = fbr_pkg::CMD_PROG_SET;
            default:           first_cmd = fbr_pkg::CMD_READ_ARRAY;
        endcase
    endfunction : first_cmd

    always_comb
    begin
        s_d      = s_q;
        s_d.done    = 1'b0;
        s_d.aborted = 1'b0;
        case (s_q.st)
            fbr_pkg::ST_IDLE:
            begin
                s_d.we_n  = 1'b1;
                s_d.cs    = fbr_pkg::DESEL;
                s_d.dq_oe = 1'b0;
                if (reset_req_i)
                begin
                    s_d.st   = fbr_pkg::ST_RST;
                    s_d.cnt  = '0;
                    s_d.rp_n = 1'b0;
                end
                else if (req_valid_i && req_op_i != fbr_pkg::OP_NONE)
                begin
                    // Setup cycle first, confirm cycle second
                    s_d.op     = req_op_i;
                    s_d.second = 1'b0;
                    s_d.addr   = req_addr_i;
                    s_d.dq     = {8'h00, first_cmd(req_op_i)};
                    s_d.st     = fbr_pkg::ST_WR;
                    s_d.cnt    = '0;
                end
            end
            fbr_pkg::ST_WR:
            begin
                s_d.cs    = fbr_pkg::SEL_ON;
                s_d.we_n  = 1'b0;
                s_d.dq_oe = 1'b1;
                s_d.cnt   = s_q.cnt + 1'b1;
                if (s_q.cnt == fbr_pkg::CNT_W'(fbr_pkg::WR_LOW_CYC))
                begin
                    s_d.we_n  = 1'b1;
                    s_d.cs    = fbr_pkg::DESEL;
                    s_d.cnt   = '0;
                    if (!s_q.second)
                    begin
                        s_d.second = 1'b1;
                        s_d.dq     = (s_q.op == fbr_pkg::OP_PROG) ? req_data_i
                                   : {8'h00, fbr_pkg::CMD_CLR_LOCKS};
                    end
                    else if (s_q.op == fbr_pkg::OP_NONE)
                    begin
                        s_d.st = fbr_pkg::ST_IDLE;
                        s_d.done = 1'b1;
                    end
                    else
                    begin
                        s_d.st       = fbr_pkg::ST_BUSY;
                        s_d.was_busy = 1'b0;
                    end
                end
            end
            fbr_pkg::ST_BUSY:
            begin
                s_d.dq_oe = 1'b0;
                if (busy_sync)
                begin
                    s_d.was_busy = 1'b1;
                end
                if (reset_req_i)
                begin
                    s_d.st       = fbr_pkg::ST_RST;
                    s_d.cnt      = '0;
                    s_d.rp_n     = 1'b0;
                    s_d.retry    = (s_q.op != fbr_pkg::OP_PROG);
                    s_d.retry_op = s_q.op;
                    s_d.aborted  = 1'b1;
                end
                else if (!busy_sync && (s_q.was_busy || s_q.cnt == '1))
                begin
                    // Released busy pin ends the operation once busy was seen or cnt saturated
                    s_d.st = fbr_pkg::ST_RDARR;
                end
                else if (s_q.cnt != '1)
                begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
            end
            fbr_pkg::ST_RDARR:
            begin
                // Read-array command before any array read
                s_d.op     = fbr_pkg::OP_NONE;
                s_d.second = 1'b1;
                s_d.dq     = {8'h00, fbr_pkg::CMD_READ_ARRAY};
                s_d.st     = fbr_pkg::ST_WR;
                s_d.cnt    = '0;
                if (s_q.op == s_q.retry_op)
                begin
                    s_d.retry = 1'b0;
                end
            end
            fbr_pkg::ST_RST:
            begin
                // Hold reset low; busy may stay low until internal reset ends
                s_d.rp_n  = 1'b0;
                s_d.we_n  = 1'b1;
                s_d.cs    = fbr_pkg::DESEL;
                s_d.dq_oe = 1'b0;
                s_d.cnt   = s_q.cnt + 1'b1;
                if (s_q.cnt >= fbr_pkg::CNT_W'(fbr_pkg::RST_LOW_CYC) && !busy_sync)
                begin
                    s_d.rp_n = 1'b1;
                    s_d.cnt  = '0;
                    s_d.st   = fbr_pkg::ST_REC;
                end
            end
            fbr_pkg::ST_REC:
            begin
                s_d.cnt = s_q.cnt + 1'b1;
                if (s_q.cnt == fbr_pkg::CNT_W'(fbr_pkg::RST_REC_CYC))
                begin
                    // Flash is back in read-array mode after reset exit
                    s_d.st   = fbr_pkg::ST_IDLE;
                    s_d.done = 1'b1;
                end
            end
            default:
            begin
                s_d.st = fbr_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_q       <= '0;
            s_q.st    <= fbr_pkg::ST_IDLE;
            s_q.we_n  <= 1'b1;
            s_q.rp_n  <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign req_ready_o         = (s_q.st == fbr_pkg::ST_IDLE) && !reset_req_i;
    assign done_o              = s_q.done;
    assign aborted_o           = s_q.aborted;
    assign retry_needed_o      = s_q.retry;
    assign retry_op_o          = s_q.retry_op;
    assign flash_addr_o        = s_q.addr;
    assign flash_dq_o          = s_q.dq;
    assign flash_dq_oe_o       = s_q.dq_oe;
    assign write_strobe_n_o    = s_q.we_n;
    assign chip_select_0_o     = s_q.cs;
    assign reset_powerdown_n_o = s_q.rp_n;
endmodule : fbr_host

// ---- verif/fbr_host_props.sv ----
// Port checker for the flash host controller
`timescale 1ns/1ps
module fbr_host_props (
    input wire logic                        clk_i,
    input wire logic                        rst_i,
    input wire logic                        write_strobe_n_o,
    input wire logic                        chip_select_0_o,
    input wire logic                        reset_powerdown_n_o,
    input wire logic [fbr_pkg::DATA_W-1:0]  flash_dq_o,
    input wire logic                        done_o,
    input wire logic                        aborted_o,
    input wire logic                        retry_needed_o,
    input wire logic [1:0]                  retry_op_o
);
    logic       strb_q;
    logic       pend_q;
    logic       erl_q;
    wire        fall = strb_q & ~write_strobe_n_o;
    wire  [7:0] cmd  = flash_dq_o[7:0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Tracks alteration writes not yet followed by read-array
    always_ff @(posedge clk_i)
    begin
        strb_q <= rst_i | write_strobe_n_o;
        if (rst_i | ~reset_powerdown_n_o)
        begin
            pend_q <= 1'b0;
            erl_q  <= 1'b0;
        end
        else if (fall)
        begin
            pend_q <= (cmd != fbr_pkg::CMD_READ_ARRAY);
            erl_q  <= (cmd == fbr_pkg::CMD_ERASE_SET) || (cmd == fbr_pkg::CMD_LOCK_SETUP);
        end
    end
    strobe_needs_select_a: assert property (!write_strobe_n_o |-> chip_select_0_o)
        else $error("write strobe low while deselected");
    strobe_width_a: assert property ($fell(write_strobe_n_o) |->
        !write_strobe_n_o [*4] ##1 write_strobe_n_o) else $error("write strobe width wrong");
    reset_no_write_a: assert property (!reset_powerdown_n_o |-> write_strobe_n_o)
        else $error("write during flash reset");
    read_before_done_a: assert property (done_o |-> !pend_q)
        else $error("done without read-array write");
    confirm_pair_a: assert property (fall && erl_q |-> cmd == fbr_pkg::CMD_CLR_LOCKS)
        else $error("setup not followed by confirm");
    confirm_soon_a: assert property (fall && erl_q == 1'b0 &&
        cmd == fbr_pkg::CMD_ERASE_SET |-> ##[2:12] fall) else $error("confirm write late");
    retry_flag_a: assert property (aborted_o && retry_op_o != fbr_pkg::OP_PROG |->
        ##[0:1] retry_needed_o) else $error("retry flag not raised");
    cover property (done_o);
    cover property (aborted_o && retry_op_o == fbr_pkg::OP_PROG);
    cover property (retry_needed_o && done_o);
endmodule : fbr_host_props
bind fbr_host fbr_host_props u_props (.clk_i, .rst_i, .write_strobe_n_o, .chip_select_0_o,
    .reset_powerdown_n_o, .flash_dq_o, .done_o, .aborted_o, .retry_needed_o, .retry_op_o);

// ---- verif/fbr_flash_model.sv ----
// Behavioural flash device model with busy pin and reset abort
`timescale 1ns/1ps
module fbr_flash_model #(
    parameter int unsigned ABORT_CYC = 30
) (
    input  wire logic        clk_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        we_n_i,
    input  wire logic        cs_i,
    input  wire logic        rp_n_i,
    input  wire logic        supply_ok_i,
    input  wire logic [15:0] busy_cyc_i,
    output logic             busy_pull_o
);
    logic [15:0] cnt_q  = '0;
    logic [7:0]  sr_q   = '0;
    logic [7:0]  dat_q  = '0;
    logic [1:0]  mode_q = '0;
    logic        wl_q   = 1'b0;
    wire         wl     = ~we_n_i & cs_i & rp_n_i;
    assign busy_pull_o = (cnt_q != 0);
    always @(posedge clk_i)
    begin
        wl_q <= wl;
        if (wl)
            dat_q <= dq_i[7:0];
        if (cnt_q != 0)
            cnt_q <= cnt_q - 16'h0001;
        if (!rp_n_i)
        begin
            mode_q <= 2'h0;
            sr_q   <= 8'h00;
            if (cnt_q > ABORT_CYC)
                cnt_q <= 16'(ABORT_CYC);
        end
        else if (wl_q && !wl)
        begin
            mode_q <= 2'h0;
            if (mode_q != 0 && !supply_ok_i)
                sr_q <= sr_q | ((mode_q == 2'h2) ? 8'h28 : 8'h08);
            else if (mode_q != 0 && mode_q != 2'h3 && dat_q != fbr_pkg::CMD_CLR_LOCKS)
                sr_q <= sr_q | 8'h30;
            else if (mode_q != 0)
                cnt_q <= busy_cyc_i;
            else if (dat_q == fbr_pkg::CMD_ERASE_SET)
                mode_q <= 2'h1;
            else if (dat_q == fbr_pkg::CMD_LOCK_SETUP)
                mode_q <= 2'h2;
            else if (dat_q == fbr_pkg::CMD_PROG_SET)
                mode_q <= 2'h3;
        end
    end
endmodule : fbr_flash_model

// ---- verif/tb.sv ----
// Self-checking testbench for the flash host controller
`timescale 1ns/1ps
module tb;
    logic             clk_i = 1'b0, rst_i = 1'b1, req_valid_i = 1'b0, reset_req_i = 1'b0;
    fbr_pkg::fbr_op_e req_op_i = fbr_pkg::OP_NONE;
    logic [23:0]      req_addr_i = '0;
    logic [23:0]      addr;
    logic [15:0]      req_data_i = '0, dq, busy_cyc = 16'h0010;
    logic             req_ready_o, done_o, aborted_o, retry_needed_o, dq_oe, we_n, cs, rp_n, pull;
    logic [1:0]       retry_op_o;
    logic [19:0]      seed = 20'd88668;
    logic             we_q = 1'b1;
    logic [7:0]       wr_q[$];
    int               failures = 0, checked = 0, dones = 0, aborts = 0;
    always #12.5 clk_i = ~clk_i;
    fbr_host u_dut (.clk_i, .rst_i, .req_valid_i, .req_ready_o, .req_op_i, .req_addr_i,
        .req_data_i, .reset_req_i, .done_o, .aborted_o, .retry_needed_o, .retry_op_o,
        .flash_addr_o(addr), .flash_dq_o(dq), .flash_dq_oe_o(dq_oe), .write_strobe_n_o(we_n),
        .chip_select_0_o(cs), .reset_powerdown_n_o(rp_n), .busy_status_pin_i(~pull));
    fbr_flash_model u_flash (.clk_i, .dq_i(dq_oe ? dq : ~dq), .we_n_i(we_n), .cs_i(cs),
        .rp_n_i(rp_n), .supply_ok_i(1'b1), .busy_cyc_i(busy_cyc), .busy_pull_o(pull));
    always @(posedge clk_i)
    begin
        we_q   <= we_n;
        dones  <= dones + int'(done_o);
        aborts <= aborts + int'(aborted_o);
        if (we_q && !we_n)
            wr_q.push_back(dq[7:0]);
    end
    function automatic logic [19:0] lfsr(input logic [19:0] s);
        return {s[18:0], s[19] ^ s[16]};
    endfunction : lfsr
    function automatic logic [7:0] setup_of(input fbr_pkg::fbr_op_e op);
        return (op == fbr_pkg::OP_ERASE) ? fbr_pkg::CMD_ERASE_SET :
            (op == fbr_pkg::OP_LOCK) ? fbr_pkg::CMD_LOCK_SETUP : fbr_pkg::CMD_PROG_SET;
    endfunction : setup_of
    task automatic final_report;
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_done(input int n);
        int d0;
        d0 = dones;
        repeat (n)
        begin
            @(posedge clk_i);
            #1;
            if (dones != d0)
                return;
        end
        check("done", 16'h0000, 16'h0001);
        final_report();
    endtask : wait_done
    task automatic issue(input fbr_pkg::fbr_op_e op, input logic [15:0] data);
        seed = lfsr(seed);
        @(posedge clk_i);
        #2;
        check("ready", req_ready_o, 1);
        req_valid_i = 1'b1;
        req_op_i = op;
        req_addr_i = {seed, 4'h0};
        req_data_i = data;
        @(posedge clk_i);
        #2;
        req_valid_i = 1'b0;
    endtask : issue
    task automatic do_op(input fbr_pkg::fbr_op_e op);
        logic [15:0] data;
        seed = lfsr(seed);
        data = {seed[15:2], 2'b01};
        busy_cyc = {8'h00, seed[19:12]} + 16'd8;
        wr_q.delete();
        issue(op, data);
        wait_done(20000);
        check("writes", 16'(wr_q.size()), 3);
        check("setup", wr_q[0], setup_of(op));
        check("confirm", wr_q[1], op == fbr_pkg::OP_PROG ? data[7:0] : fbr_pkg::CMD_CLR_LOCKS);
        check("address lo", addr[15:0], req_addr_i[15:0]);
        check("address hi", {8'h00, addr[23:16]}, {8'h00, req_addr_i[23:16]});
        check("read array", wr_q[2], fbr_pkg::CMD_READ_ARRAY);
    endtask : do_op
    task automatic do_abort(input fbr_pkg::fbr_op_e op);
        int a0;
        a0 = aborts;
        busy_cyc = 16'd5000;
        issue(op, 16'h1235);
        repeat (200)
            if (!pull)
                @(posedge clk_i);
        check("busy seen", pull, 1);
        #2;
        reset_req_i = 1'b1;
        @(posedge clk_i);
        #2;
        reset_req_i = 1'b0;
        wait_done(4000);
        check("aborted", 16'(aborts - a0), 1);
        check("retry", retry_needed_o, op != fbr_pkg::OP_PROG);
        check("retry op", retry_op_o, op);
        do_op(op);
        check("retry clear", retry_needed_o, 0);
    endtask : do_abort
    initial
    begin
        repeat (8) @(posedge clk_i);
        #2;
        rst_i = 1'b0;
        check("strobe idle", we_n, 1);
        check("select idle", cs, 0);
        wr_q.delete();
        issue(fbr_pkg::OP_NONE, 16'h0000);
        repeat (30) @(posedge clk_i);
        check("no write", 16'(wr_q.size()), 0);
        for (int k = 0; k < 8; k++)
            do_op(fbr_pkg::fbr_op_e'(2'(1 + k % 3)));
        do_abort(fbr_pkg::OP_ERASE);
        do_abort(fbr_pkg::OP_LOCK);
        do_abort(fbr_pkg::OP_PROG);
        @(posedge clk_i);
        #2;
        reset_req_i = 1'b1;
        @(posedge clk_i);
        #2;
        reset_req_i = 1'b0;
        wait_done(4000);
        check("idle reset aborts", 16'(aborts), 3);
        check("idle reset retry", retry_needed_o, 0);
        final_report();
    end
endmodule : tb
